// File: rtl/rc_integ.sv
// Contract
// - Slice config address into bus/dev/func/reg fields
// - ARI bus: bits 19:12 form function
// - Several config windows at fixed bases
// - Outbound device or non-cached access supported
// - Normal-mapped outbound unaligned accesses completed
// - Inbound addresses passed without any change
// - Message interrupts are writes, edge events
// - Each message interrupt gets unique identifier
// - Four legacy lines drive distinct shared inputs
// - Legacy delivery uses no vendor registers
// - Classify inbound address memory or device
// - Device-region inbound: ordered, no merge, uncached
// - No-snoop memory inbound gets non-cached
// - Snooping memory inbound is cacheable shared
// - Root complex inner shareable with processors
// - With translation unit keep its attributes
// - Optional no-snoop override of cacheable attribute
`default_nettype none
module rc_integ
    import rc_integ_pkg::*;
#(
    parameter bit HAS_XLATE    = 1'b0, // Translation unit present
    parameter bit NS_OVERRIDE  = 1'b1  // No-snoop replaces cacheable
)(
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Outbound access from processing elements
    input  wire logic                  ob_valid,
    output logic                       ob_ready,
    input  wire logic [ADDR_W-1:0]     ob_addr,
    input  wire logic                  ob_write,
    input  wire logic [DATA_W-1:0]     ob_wdata,
    input  wire logic [STRB_W-1:0]     ob_strb,
    input  wire logic [3:0]            ob_attr,
    input  wire logic                  ob_ari,
    output logic                       ob_rsp_valid,
    output logic [DATA_W-1:0]          ob_rdata,
    output logic                       ob_err,
    // Request to root complex
    output logic                       rc_valid,
    input  wire logic                  rc_ready,
    output logic                       rc_cfg,
    output logic [BUS_BITS-1:0]        rc_bus,
    output logic [4:0]                 rc_dev,
    output logic [7:0]                 rc_func,
    output logic [9:0]                 rc_reg,
    output logic [ADDR_W-1:0]          rc_addr,
    output logic                       rc_write,
    output logic [DATA_W-1:0]          rc_wdata,
    output logic [STRB_W-1:0]          rc_strb,
    input  wire logic                  rc_rsp_valid,
    input  wire logic [DATA_W-1:0]     rc_rdata,
    input  wire logic                  rc_rsp_err,
    // Inbound transaction from devices
    input  wire logic                  ib_valid,
    output logic                       ib_ready,
    input  wire logic [ADDR_W-1:0]     ib_addr,
    input  wire logic                  ib_no_snoop,
    input  wire logic [3:0]            ib_xlate_attr,
    // Inbound transaction to memory system or translation unit
    output logic                       mem_valid,
    input  wire logic                  mem_ready,
    output logic [ADDR_W-1:0]          mem_addr,
    output logic [3:0]                 mem_attr,
    output logic [1:0]                 mem_share,
    output logic                       mem_ordered,
    output logic                       mem_no_merge,
    // Legacy interrupt messages
    input  wire logic [NUM_LEGACY-1:0] intx_assert,
    input  wire logic [NUM_LEGACY-1:0] intx_deassert,
    output logic [NUM_LEGACY-1:0]      legacy_irq
);

    // Registered state of the outbound and inbound paths
    typedef struct packed {
        ob_state_t           ob_st;    // Outbound path state
        logic                cfg;      // Access targets config space
        logic [BUS_BITS-1:0] bus;      // Decoded bus number
        logic [4:0]          dev;      // Decoded device
        logic [7:0]          func;     // Decoded function
        logic [9:0]          regn;     // Decoded dword register
        logic [ADDR_W-1:0]   addr;     // Outbound address
        logic                write;    // Write flag
        logic [DATA_W-1:0]   wdata;    // Write data
        logic [STRB_W-1:0]   strb;     // Byte enables
        logic                rsp_v;    // Response pulse
        logic [DATA_W-1:0]   rdata;    // Response data
        logic                err;      // Response error
        logic                ib_v;     // Inbound beat pending
        logic [ADDR_W-1:0]   ib_addr;  // Inbound address
        logic [3:0]          ib_attr;  // Inbound attributes
        logic [1:0]          ib_share; // Inbound shareability
        logic                ib_dev;   // Inbound targets device region
    } state_t;

    state_t state;      // Registered state
    state_t next_state; // Next state

    // Window hit decode
    logic [NUM_WIN-1:0]    win_hit;  // Which window matches
    logic [ADDR_W-1:0]     win_off;  // Offset inside the hit window
    logic [ADDR_W-1:0]     win_base [NUM_WIN]; // Window bases
    logic                  any_hit;  // Address in some window
    logic                  attr_ok;  // Outbound attribute accepted
    logic                  ib_is_dev; // Inbound device classification
    logic [3:0]            ib_attr_c; // Inbound attribute chosen
    logic [1:0]            ib_share_c; // Inbound shareability chosen

    assign win_base[0] = WIN0_BASE;
    assign win_base[1] = WIN1_BASE;

    // Match each window against its fixed base
    always_comb begin
        win_off = '0;
        for (int i = 0; i < NUM_WIN; i++) begin
            win_hit[i] = (ob_addr[ADDR_W-1:WIN_BITS] ==
                          win_base[i][ADDR_W-1:WIN_BITS]);
            if (win_hit[i]) begin
                win_off = ob_addr - win_base[i];
            end
        end
        any_hit = |win_hit;
    end

    // Memory space accepts device, non-cached and normal mappings
    always_comb begin
        attr_ok = (ob_attr == ATTR_DEVICE) ||
                  (ob_attr == ATTR_NONCACHED) ||
                  (ob_attr == ATTR_CACHED);
    end

    // Classify inbound address and choose its attributes
    always_comb begin
        ib_is_dev = (ib_addr >= DEV_REGION_BASE) &&
                    (ib_addr <= DEV_REGION_LIMIT);
        ib_attr_c = ATTR_CACHED;
        ib_share_c = SHARE_INNER;
        if (HAS_XLATE) begin
            ib_is_dev = 1'b0;
            ib_attr_c = ib_xlate_attr;
            if (NS_OVERRIDE && ib_no_snoop &&
                ib_xlate_attr == ATTR_CACHED) begin
                ib_attr_c = ATTR_NONCACHED;
            end
        end else if (ib_is_dev) begin
            ib_attr_c = ATTR_DEVICE;
            ib_share_c = SHARE_NONE;
        end else if (ib_no_snoop) begin
            ib_attr_c = ATTR_NONCACHED;
        end else begin
            ib_attr_c = ATTR_CACHED;
            ib_share_c = SHARE_INNER;
        end
    end

    // Next-state logic for both paths
    always_comb begin
        next_state = state;
        next_state.rsp_v = 1'b0;
        case (state.ob_st)
            OB_IDLE: begin
                if (ob_valid) begin
                    next_state.addr = ob_addr;
                    next_state.write = ob_write;
                    next_state.wdata = ob_wdata;
                    // Any strobe pattern passes, so unaligned works
                    next_state.strb = ob_strb;
                    next_state.cfg = any_hit;
                    next_state.bus = win_off[BUS_LSB+BUS_BITS-1:BUS_LSB];
                    next_state.regn = win_off[EXTREG_MSB:REG_LSB];
                    if (ob_ari) begin
                        next_state.dev = 5'h00;
                        next_state.func = win_off[ARI_MSB:ARI_LSB];
                    end else begin
                        next_state.dev = win_off[DEV_MSB:DEV_LSB];
                        next_state.func = {5'h00,
                            win_off[FUNC_MSB:FUNC_LSB]};
                    end
                    if (!any_hit && !attr_ok) begin
                        next_state.rsp_v = 1'b1;
                        next_state.err = 1'b1;
                        next_state.rdata = '0;
                    end else begin
                        next_state.ob_st = OB_REQ;
                    end
                end
            end
            OB_REQ: begin
                if (rc_ready) begin
                    next_state.ob_st = OB_RSP;
                end
            end
            OB_RSP: begin
                if (rc_rsp_valid) begin
                    next_state.rsp_v = 1'b1;
                    next_state.rdata = rc_rdata;
                    next_state.err = rc_rsp_err;
                    next_state.ob_st = OB_IDLE;
                end
            end
            default: begin
                next_state.ob_st = OB_IDLE;
            end
        endcase
        // Inbound single-entry stage, address copied bit for bit
        if (state.ib_v && mem_ready) begin
            next_state.ib_v = 1'b0;
        end
        if (ib_ready && ib_valid) begin
            next_state.ib_v = 1'b1;
            next_state.ib_addr = ib_addr;
            next_state.ib_attr = ib_attr_c;
            next_state.ib_share = ib_share_c;
            next_state.ib_dev = ib_is_dev;
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= '0;
            state.ob_st <= OB_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Outbound outputs
    assign ob_ready = (state.ob_st == OB_IDLE);
    assign ob_rsp_valid = state.rsp_v;
    assign ob_rdata = state.rdata;
    assign ob_err = state.err;
    assign rc_valid = (state.ob_st == OB_REQ);
    assign rc_cfg = state.cfg;
    assign rc_bus = state.bus;
    assign rc_dev = state.dev;
    assign rc_func = state.func;
    assign rc_reg = state.regn;
    assign rc_addr = state.addr;
    assign rc_write = state.write;
    assign rc_wdata = state.wdata;
    assign rc_strb = state.strb;

    // Inbound outputs; message interrupt writes pass as plain writes
    // so they hit the controller registers untouched
    assign ib_ready = !state.ib_v || mem_ready;
    assign mem_valid = state.ib_v;
    assign mem_addr = state.ib_addr;
    assign mem_attr = state.ib_attr;
    assign mem_share = state.ib_share;
    assign mem_ordered = state.ib_dev;
    assign mem_no_merge = state.ib_dev;

    // Each legacy line drives its own shared input wire
    for (genvar g = 0; g < NUM_LEGACY; g++) begin : g_legacy
        legacy_line u_line (
            .clk          (clk),
            .rst          (rst),
            .assert_msg   (intx_assert[g]),
            .deassert_msg (intx_deassert[g]),
            .level        (legacy_irq[g])
        );
    end
endmodule // rc_integ
`default_nettype wire

// File: inc/rc_integ_pkg.sv
`default_nettype none
package rc_integ_pkg;
    // Address and data widths of the system side
    localparam int ADDR_W = 48;
    localparam int DATA_W = 64;
    localparam int STRB_W = 8;
    // Number of configuration windows and bus bits per window
    localparam int NUM_WIN = 2;
    localparam int BUS_BITS = 8;
    // Field positions of the configuration address
    localparam int BUS_LSB = 20;
    localparam int DEV_MSB = 19;
    localparam int DEV_LSB = 15;
    localparam int FUNC_MSB = 14;
    localparam int FUNC_LSB = 12;
    localparam int EXTREG_MSB = 11;
    localparam int EXTREG_LSB = 8;
    localparam int REG_MSB = 7;
    localparam int REG_LSB = 2;
    localparam int BYTE_MSB = 1;
    localparam int ARI_MSB = 19;
    localparam int ARI_LSB = 12;
    // Window size in address bits: bus, device, function, register
    localparam int WIN_BITS = BUS_LSB + BUS_BITS;
    // Fixed window base addresses, arbitrary placement
    localparam logic [ADDR_W-1:0] WIN0_BASE = 48'h0000_4000_0000;
    localparam logic [ADDR_W-1:0] WIN1_BASE = 48'h0000_5000_0000;
    // Device region of inbound address space (no translation unit)
    localparam logic [ADDR_W-1:0] DEV_REGION_BASE = 48'h0000_0000_0000;
    localparam logic [ADDR_W-1:0] DEV_REGION_LIMIT = 48'h0000_3FFF_FFFF;
    // Memory attribute encodings on the system side
    localparam logic [3:0] ATTR_DEVICE = 4'h0;
    localparam logic [3:0] ATTR_NONCACHED = 4'h3;
    localparam logic [3:0] ATTR_CACHED = 4'hF;
    // Shareability encodings
    localparam logic [1:0] SHARE_NONE = 2'h0;
    localparam logic [1:0] SHARE_INNER = 2'h3;
    // Legacy interrupt lines
    localparam int NUM_LEGACY = 4;
    // Reset values
    localparam logic [NUM_LEGACY-1:0] LEGACY_RST = 4'h0;
    // Outbound path states
    typedef enum logic [2:0] {
        OB_IDLE = 3'b001,
        OB_REQ  = 3'b010,
        OB_RSP  = 3'b100
    } ob_state_t;
endpackage
`default_nettype wire

// File: rtl/legacy_line.sv
`default_nettype none
// One legacy interrupt line held as a level between assert and deassert
module legacy_line
    import rc_integ_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic assert_msg,
    input  wire logic deassert_msg,
    output logic      level
);
    typedef struct packed {
        logic level; // Held line level
    } line_state_t;

    line_state_t state;      // Registered state
    line_state_t next_state; // Next state

    // Assert sets, deassert clears; an assert in the same cycle wins
    always_comb begin
        next_state = state;
        if (assert_msg) begin
            next_state.level = 1'b1;
        end else if (deassert_msg) begin
            next_state.level = 1'b0;
        end
    end

    // Register the line
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign level = state.level;
endmodule // legacy_line
`default_nettype wire

// File: verification/rc_integ_chk.sv
`default_nettype none
// Watches decode, attribute and handshake timing at the bridge ports
module rc_integ_chk
    import rc_integ_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              ob_valid,
    input wire logic              ob_ready,
    input wire logic [ADDR_W-1:0] ob_addr,
    input wire logic              ob_ari,
    input wire logic              rc_valid,
    input wire logic              rc_ready,
    input wire logic              rc_cfg,
    input wire logic [7:0]        rc_bus,
    input wire logic [4:0]        rc_dev,
    input wire logic [7:0]        rc_func,
    input wire logic [9:0]        rc_reg,
    input wire logic [ADDR_W-1:0] rc_addr,
    input wire logic              ib_valid,
    input wire logic              ib_ready,
    input wire logic [ADDR_W-1:0] ib_addr,
    input wire logic              ib_no_snoop,
    input wire logic              mem_valid,
    input wire logic              mem_ready,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [3:0]        mem_attr,
    input wire logic [1:0]        mem_share,
    input wire logic              mem_ordered,
    input wire logic              mem_no_merge
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [ADDR_W-1:0] addr_q; // Address of the last taken request
    logic              ari_q;  // Function reading of that request
    logic              hit;    // That request fell in a window
    // Keep the last taken outbound request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_q <= '0;
            ari_q  <= 1'b0;
        end else if (ob_valid && ob_ready) begin
            addr_q <= ob_addr;
            ari_q  <= ob_ari;
        end
    end
    assign hit = addr_q[47:28] == WIN0_BASE[47:28]
              || addr_q[47:28] == WIN1_BASE[47:28];
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence ob_take;
        ob_valid && ob_ready;
    endsequence
    sequence ib_take;
        ib_valid && ib_ready;
    endsequence
    chk_cfg_fields: assert property (ob_take ##1 hit |-> rc_valid && rc_cfg
        && rc_bus == addr_q[27:20] && rc_reg == addr_q[11:2])
        else $error("config bus or register field wrong");
    chk_cfg_devfn: assert property (ob_take ##1 hit && !ari_q |->
        rc_dev == addr_q[19:15] && rc_func == {5'h0, addr_q[14:12]})
        else $error("config device or function field wrong");
    chk_cfg_ari: assert property (ob_take ##1 hit && ari_q |->
        rc_dev == 5'h0 && rc_func == addr_q[19:12])
        else $error("wide function field wrong");
    chk_ob_mem: assert property (ob_take ##1 !hit && rc_valid |->
        !rc_cfg && rc_addr == addr_q)
        else $error("outbound memory address altered");
    chk_rc_hold: assert property (rc_valid && !rc_ready |=>
        rc_valid && $stable(rc_addr))
        else $error("root complex request dropped early");
    chk_ib_addr: assert property (ib_take |=>
        mem_valid && mem_addr == $past(ib_addr))
        else $error("inbound address altered");
    chk_ib_dev: assert property ((ib_take and (ib_addr <= DEV_REGION_LIMIT)) |=>
        mem_attr == ATTR_DEVICE && mem_ordered && mem_no_merge)
        else $error("device region access attributes wrong");
    chk_ib_nosnoop: assert property ((ib_take and (ib_no_snoop
        && ib_addr > DEV_REGION_LIMIT)) |=> mem_attr == ATTR_NONCACHED)
        else $error("no-snoop memory access not non-cached");
    chk_ib_snoop: assert property ((ib_take and (!ib_no_snoop
        && ib_addr > DEV_REGION_LIMIT)) |=> mem_attr == ATTR_CACHED
        && mem_share == SHARE_INNER)
        else $error("snooping access not cached and shared");
    chk_mem_hold: assert property (mem_valid && !mem_ready |=>
        mem_valid && $stable(mem_addr))
        else $error("memory request dropped early");
endmodule // rc_integ_chk
`default_nettype wire

// File: verification/rc_model.sv
`default_nettype none
// Root complex stand-in: takes one request, answers after a delay
module rc_model
    import rc_integ_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rc_valid,
    output logic                   rc_ready,
    input  wire logic              rc_cfg,
    input  wire logic [7:0]        rc_bus,
    input  wire logic [4:0]        rc_dev,
    input  wire logic [7:0]        rc_func,
    input  wire logic [9:0]        rc_reg,
    input  wire logic [ADDR_W-1:0] rc_addr,
    input  wire logic [1:0]        slow,
    output logic                   rc_rsp_valid,
    output logic [DATA_W-1:0]      rc_rdata,
    output logic                   rc_rsp_err
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [DATA_W-1:0] ans; // Answer echoes the decoded request
    // Serve one request at a time; slow sets both waits
    initial begin
        rc_ready     = 1'b0;
        rc_rsp_valid = 1'b0;
        rc_rsp_err   = 1'b0;
        rc_rdata     = '1;
        forever begin
            @(posedge clk);
            #1;
            if (rc_valid === 1'b1) begin
                repeat (slow) begin
                    @(posedge clk);
                    #1;
                end
                ans = rc_cfg ? {33'h0, rc_bus, rc_dev, rc_func, rc_reg}
                             : {16'h0, rc_addr};
                rc_ready = 1'b1;
                @(posedge clk);
                #1;
                rc_ready = 1'b0;
                repeat (slow) begin
                    @(posedge clk);
                    #1;
                end
                rc_rsp_valid = 1'b1;
                rc_rdata     = ans;
                @(posedge clk);
                #1;
                rc_rsp_valid = 1'b0;
                rc_rdata     = ~ans; // No stale data once released
            end
        end
    end
endmodule // rc_model
`default_nettype wire

// File: verification/tb_rc_integ.sv
`default_nettype none
// Drives both bridge directions and the legacy lines, checks results
module tb_rc_integ
    import rc_integ_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Outbound attributes tried: device, non-cached, normal, illegal
    localparam logic [3:0] ATTR_ALL [4] = '{ATTR_DEVICE, ATTR_NONCACHED,
                                            ATTR_CACHED, 4'h5};
    typedef struct packed {
        logic [DATA_W-1:0] d;
        logic e;
        logic cd;
    } ob_exp_t;
    typedef struct packed {
        logic [ADDR_W-1:0] a;
        logic [3:0] t;
        logic cs;
    } mem_exp_t;
    logic              clk, rst, ob_valid, ob_ready, ob_write, ob_ari;
    logic              ob_rsp_valid, ob_err, rc_valid, rc_ready, rc_cfg;
    logic              rc_write, rc_rsp_valid, rc_rsp_err, ib_valid;
    logic              ib_ready, ib_no_snoop, mem_valid, mem_ready;
    logic              mem_ordered, mem_no_merge;
    logic [ADDR_W-1:0] ob_addr, rc_addr, ib_addr, mem_addr, a;
    logic [DATA_W-1:0] ob_wdata, ob_rdata, rc_wdata, rc_rdata;
    logic [7:0]        ob_strb, rc_strb, rc_bus, rc_func;
    logic [3:0]        ob_attr, ib_xlate_attr, mem_attr;
    logic [3:0]        intx_assert, intx_deassert, legacy_irq;
    logic [4:0]        rc_dev;
    logic [9:0]        rc_reg;
    logic [1:0]        mem_share, slow;
    int                error_cnt, tests_run;
    ob_exp_t           q_ob[$];
    mem_exp_t          q_mem[$];
    ob_exp_t           ob_x;
    mem_exp_t          mem_x;
    rc_integ i_rc_integ (.*);
    rc_model i_rc_model (.*);
    // Free-running 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic cmp(string nm, logic [63:0] e, logic [63:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic end_sim;
        $display("mismatches %0d of %0d checks", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    function automatic logic [63:0] cfg_exp(logic [47:0] x, logic r);
        return {33'h0, x[27:20], r ? 5'h0 : x[19:15],
                r ? x[19:12] : {5'h0, x[14:12]}, x[11:2]};
    endfunction
    // One outbound request, then wait for its answer
    task automatic ob_go(logic [47:0] x, logic [3:0] t, logic r, ob_exp_t p);
        ob_valid = 1'b1;
        ob_addr  = x;
        ob_attr  = t;
        ob_ari   = r;
        ob_wdata = {$urandom, $urandom};
        for (int n = 0; n < 99 && ob_ready !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        q_ob.push_back(p);
        @(posedge clk);
        #1;
        ob_valid = 1'b0;
        slow     = 2'($urandom);
        for (int n = 0; n < 99 && q_ob.size() != 0; n++) begin
            @(posedge clk);
            #1;
        end
    endtask
    // One inbound transfer, valid left high for back-to-back use
    task automatic ib_go(logic [47:0] x, logic ns);
        ib_valid    = 1'b1;
        ib_addr     = x;
        ib_no_snoop = ns;
        for (int n = 0; n < 99 && ib_ready !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        q_mem.push_back('{x, x <= DEV_REGION_LIMIT ? ATTR_DEVICE
            : ns ? ATTR_NONCACHED : ATTR_CACHED,
            x > DEV_REGION_LIMIT && !ns});
        @(posedge clk);
        #1;
    endtask
    // Answer monitor, random memory-side stalls
    always @(posedge clk) begin
        mem_ready <= 1'($urandom);
        if (ob_rsp_valid === 1'b1) begin
            ob_x = q_ob.pop_front();
            cmp("ob_err", 64'(ob_x.e), 64'(ob_err));
            if (ob_x.cd) cmp("ob_rdata", ob_x.d, ob_rdata);
        end
        if (mem_valid === 1'b1 && mem_ready === 1'b1) begin
            mem_x = q_mem.pop_front();
            cmp("mem_addr", 64'(mem_x.a), 64'(mem_addr));
            cmp("mem_attr", 64'(mem_x.t), 64'(mem_attr));
            if (mem_x.cs) cmp("mem_share", 64'(SHARE_INNER), 64'(mem_share));
        end
    end
    initial begin
        #100000;
        error_cnt++;
        end_sim();
    end
    // Main sequence
    initial begin
        {rst, ob_valid, ob_write, ob_ari, ib_valid, ib_no_snoop} = 6'h20;
        {ob_addr, ob_wdata, ob_attr, ib_addr, slow} = '0;
        {intx_assert, intx_deassert} = 8'h00;
        ob_strb       = 8'hFF;
        ib_xlate_attr = 4'h0;
        void'($urandom(32'hEEF9));
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        cmp("legacy_rst", 64'(LEGACY_RST), 64'(legacy_irq));
        for (int i = 0; i < 8; i++) begin
            a = {i[0] ? WIN1_BASE[47:28] : WIN0_BASE[47:28], 28'($urandom)};
            if (i == 7) a[27:0] = 28'hFFFFFFF;
            ob_go(a, 4'($urandom), i[1], '{cfg_exp(a, i[1]), 1'b0, 1'b1});
        end
        foreach (ATTR_ALL[k]) begin
            a = {16'h0001, $urandom};
            ob_go(a, ATTR_ALL[k], 1'b0, '{{16'h0, a}, k == 3, k != 3});
        end
        for (int i = 0; i < 24; i++) begin
            a = i % 3 == 0 ? {18'h0, 30'($urandom)} : {16'h0002, $urandom};
            if (i == 1) a = DEV_REGION_LIMIT;
            if (i == 2) a = DEV_REGION_LIMIT + 48'h1;
            ib_go(a, 1'($urandom));
        end
        ib_valid = 1'b0;
        intx_assert = 4'hF;
        @(posedge clk);
        #1;
        {intx_assert, intx_deassert} = 8'h05;
        cmp("legacy_set", 64'h0F, 64'(legacy_irq));
        @(posedge clk);
        #1;
        intx_deassert = 4'h0;
        cmp("legacy_clr", 64'h0A, 64'(legacy_irq));
        repeat (40) @(posedge clk);
        cmp("queues", 64'h0, 64'(q_ob.size() + q_mem.size()));
        end_sim();
    end
endmodule // tb_rc_integ
bind rc_integ rc_integ_chk i_rc_integ_chk (.*);
`default_nettype wire
